// *** hdl/adcrb_core_if.sv ***
// Signals between the register bank and its helper blocks
`timescale 1ns/1ps
`default_nettype none
interface adcrb_core_if;
    logic dr_tick;
    logic [23:0] raw_code;
    logic off_en;
    logic gain_en;
    logic [23:0] off_corr;
    logic [23:0] gain_corr;
    logic [23:0] corr_code;
    logic corr_valid;
    logic mod_tick;
    logic restart;
    logic [11:0] delay_val;
    logic [11:0] osr_half;
    logic conv_start;
    logic conv_reset;
    modport bank(output dr_tick, raw_code, off_en, gain_en, off_corr,
                 gain_corr, mod_tick, restart, delay_val, osr_half,
                 input corr_code, corr_valid, conv_start, conv_reset);
    modport corr(input dr_tick, raw_code, off_en, gain_en, off_corr,
                 gain_corr, output corr_code, corr_valid);
    modport dly(input mod_tick, restart, delay_val, osr_half,
                output conv_start, conv_reset);
endinterface
`default_nettype wire

// *** hdl/adcrb_corr.sv ***
// Offset and gain correction of the raw conversion code
`timescale 1ns/1ps
`default_nettype none
module adcrb_corr (
    input wire logic clk_in,
    input wire logic srst_in,
    adcrb_core_if.corr cif
);
    logic signed [25:0] sum_d;
    logic [23:0] off_d;
    logic signed [47:0] prod_d;
    logic signed [25:0] tot_d;
    logic [23:0] code_d;

    // R05 - offset then gain
    always_comb begin
        sum_d = $signed({{2{cif.raw_code[23]}}, cif.raw_code});
        if (cif.off_en) begin
            sum_d = sum_d + $signed({{2{cif.off_corr[23]}}, cif.off_corr});
        end
        off_d = adcrb_pkg::sat24(sum_d);
        prod_d = $signed(off_d) * $signed(cif.gain_corr);
        tot_d = $signed({{2{off_d[23]}}, off_d})
              + $signed({prod_d[47], prod_d[47:23]});
        code_d = cif.gain_en ? adcrb_pkg::sat24(tot_d) : off_d;
    end

    // R04 - whole word per event
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cif.corr_code <= 24'h000000;
            cif.corr_valid <= 1'b0;
        end else begin
            cif.corr_valid <= cif.dr_tick;
            if (cif.dr_tick) begin
                cif.corr_code <= code_d;
            end
        end
    end
endmodule
`default_nettype wire

// *** hdl/adcrb_delay.sv ***
// Conversion start delay counter on modulator ticks
`timescale 1ns/1ps
`default_nettype none
module adcrb_delay (
    input wire logic clk_in,
    input wire logic srst_in,
    adcrb_core_if.dly dif
);
    logic [12:0] count_q;
    logic busy_q;

    // R11 - field plus OSR/2
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count_q <= {1'b0, adcrb_pkg::OSR_HALF_MIN} << adcrb_pkg::OSR_RST;
            busy_q <= 1'b1;
            dif.conv_start <= 1'b0;
        end else if (dif.restart) begin
            count_q <= {1'b0, dif.delay_val} + {1'b0, dif.osr_half};
            busy_q <= 1'b1;
            dif.conv_start <= 1'b0;
        end else begin
            dif.conv_start <= 1'b0;
            if (busy_q && dif.mod_tick) begin
                if (count_q == 13'h0000) begin
                    busy_q <= 1'b0;
                    dif.conv_start <= 1'b1;
                end else begin
                    count_q <= count_q - 13'h0001;
                end
            end
        end
    end

    // R10 - reset pulse on write
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            dif.conv_reset <= 1'b0;
        end else begin
            dif.conv_reset <= dif.restart;
        end
    end
endmodule
`default_nettype wire

// *** hdl/adcrb_pkg.sv ***
// Constants and helpers of the converter register bank
// Notes on behaviour
// R01 - Result holds newest conversion, read-only
// R02 - Read sequence start freezes result snapshot
// R03 - New result caught during sequence, snapshot intact
// R04 - All result bytes refresh on data-rate event
// R05 - Result corrected when either correction enabled
// R06 - Result formatted 16, 24 or 32 bits
// R07 - Modulator register refreshed every modulator tick
// R08 - Four comparator bits, reset 0011, rest zero
// R09 - Host should not write modulator register
// R10 - Delay register write restarts the converter
// R11 - Start delay is field plus OSR/2
// R12 - Gain codes 0-5 give 1..32, else 1
// R13 - Unimplemented bits read zero, ignore writes
// R14 - Read loop setting steers address increment
// R15 - Read loop field is status bits 23:22
// R16 - Write loop bit cycles writable registers
// R17 - Register updates follow converter tick events
package adcrb_pkg;
    localparam logic [4:0] IDX_RESULT = 5'h00;
    localparam logic [4:0] IDX_MOD = 5'h08;
    localparam logic [4:0] IDX_DELAY = 5'h0a;
    localparam logic [4:0] IDX_GAIN = 5'h0b;
    localparam logic [4:0] IDX_STATUS = 5'h0c;
    localparam logic [4:0] IDX_CONFIG = 5'h0d;
    localparam logic [4:0] IDX_CFG_END = 5'h0e;
    localparam logic [4:0] IDX_OFFCORR = 5'h0f;
    localparam logic [4:0] IDX_GAINCORR = 5'h10;
    localparam logic [4:0] IDX_SEQ_ADDR = 5'h14;
    localparam logic [4:0] IDX_SEQ_DATA = 5'h15;
    localparam logic [4:0] IDX_LAST = 5'h1f;
    localparam int RD_LOOP_LO = 22;
    localparam int WR_LOOP_BIT = 21;
    localparam int WIDTH_LO = 16;
    localparam int OFF_EN_BIT = 23;
    localparam int GAIN_EN_BIT = 22;
    localparam int OSR_LO = 13;
    localparam int DELAY_W = 12;
    localparam int COMP_W = 4;
    localparam int GCODE_W = 3;
    localparam logic [2:0] STATUS_RST = 3'h5;
    localparam logic [1:0] WIDTH_RST = 2'h1;
    localparam logic [2:0] OSR_RST = 3'h3;
    localparam logic [3:0] MOD_RST = 4'h3;
    localparam logic [11:0] OSR_HALF_MIN = 12'h010;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        LOOP_SAME = 2'h0,
        LOOP_GROUP = 2'h1,
        LOOP_TYPE = 2'h2,
        LOOP_MAP = 2'h3
    } adcrb_loop_t;

    typedef enum logic [1:0] {
        FMT_16 = 2'h0,
        FMT_24 = 2'h1,
        FMT_32Z = 2'h2,
        FMT_32S = 2'h3
    } adcrb_fmt_t;

    // Next address within the loop set of the given mode
    function automatic logic [4:0] next_idx(input logic [4:0] idx,
                                            input adcrb_loop_t mode);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = idx;
        hi = idx;
        unique case (mode)
            LOOP_MAP: begin
                lo = IDX_RESULT;
                hi = IDX_LAST;
            end
            LOOP_TYPE: begin
                lo = (idx == IDX_RESULT) ? IDX_RESULT : IDX_MOD;
                hi = (idx == IDX_RESULT) ? IDX_RESULT : IDX_LAST;
            end
            LOOP_GROUP: begin
                if (idx < IDX_MOD) begin
                    lo = IDX_RESULT;
                    hi = IDX_RESULT;
                end else if (idx < IDX_STATUS) begin
                    lo = IDX_MOD;
                    hi = IDX_GAIN;
                end else if (idx < IDX_OFFCORR) begin
                    lo = IDX_STATUS;
                    hi = IDX_CFG_END;
                end else if (idx <= IDX_GAINCORR) begin
                    lo = IDX_OFFCORR;
                    hi = IDX_GAINCORR;
                end else begin
                    lo = idx;
                    hi = idx;
                end
            end
            LOOP_SAME: begin
                lo = idx;
                hi = idx;
            end
        endcase
        next_idx = (idx == hi) ? lo : idx + 5'h01;
    endfunction

    // Gain code to multiplier, reserved codes act as one
    function automatic logic [5:0] gain_of(input logic [2:0] code);
        gain_of = (code > 3'h5) ? 6'h01 : 6'h01 << code;
    endfunction

    // Clamp a wide signed value into 24 bits
    function automatic logic [23:0] sat24(input logic signed [25:0] v);
        if (v > 26'sh07fffff) begin
            sat24 = 24'h7fffff;
        end else if (v < -26'sh0800000) begin
            sat24 = 24'h800000;
        end else begin
            sat24 = v[23:0];
        end
    endfunction
endpackage

// *** hdl/adcrb_top.sv ***
// Register bank of the converter front end, Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module adcrb_top (
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic [6:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    output logic [1:0] AVS_RESPONSE_OUT,
    input wire logic DR_TICK_IN,
    input wire logic [23:0] RAW_CODE_IN,
    input wire logic MOD_TICK_IN,
    input wire logic [3:0] COMP_IN,
    output logic CONV_START_OUT,
    output logic CONV_RESET_OUT,
    output logic [5:0] AMP_GAIN_OUT
);
    adcrb_core_if cif ();

    logic [4:0] idx;
    logic [4:0] eff_idx;
    logic take;
    logic wr_take;
    logic rd_take;
    logic mapped;
    logic seq_acc;
    logic [23:0] wmask;
    logic [23:0] wval;
    logic [31:0] rdata_d;
    logic [4:0] ptr_d;
    logic [23:0] live_d;

    logic [3:0] mod_q;
    logic [11:0] delay_q;
    logic [2:0] gcode_q;
    logic [1:0] rd_loop_q;
    logic wr_loop_q;
    logic [1:0] width_q;
    logic off_en_q;
    logic gain_en_q;
    logic [2:0] osr_q;
    logic [23:0] offc_q;
    logic [23:0] gainc_q;
    logic [23:0] live_q;
    logic [23:0] snap_q;
    logic [4:0] ptr_q;
    logic seq_act_q;
    logic restart_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;
    logic [5:0] gain_q;

    // R06 - width shapes result
    function automatic logic [31:0] fmt(input logic [23:0] v,
                                        input logic [1:0] w);
        logic [16:0] r;
        r = {v[23], v[23:8]} + {16'h0000, v[7]};
        fmt = 32'h00000000;
        unique case (adcrb_pkg::adcrb_fmt_t'(w))
            adcrb_pkg::FMT_16: begin
                // Rounding must not wrap past full scale
                fmt[15:0] = (r[16] != r[15]) ? v[23:8] : r[15:0];
            end
            adcrb_pkg::FMT_24: fmt[23:0] = v;
            adcrb_pkg::FMT_32Z: fmt = {v, 8'h00};
            adcrb_pkg::FMT_32S: fmt = {{8{v[23]}}, v};
        endcase
    endfunction

    function automatic logic is_mapped(input logic [4:0] i);
        is_mapped = (i == adcrb_pkg::IDX_RESULT)
                  || (i == adcrb_pkg::IDX_MOD)
                  || (i == adcrb_pkg::IDX_DELAY)
                  || (i == adcrb_pkg::IDX_GAIN)
                  || (i == adcrb_pkg::IDX_STATUS)
                  || (i == adcrb_pkg::IDX_CONFIG)
                  || (i == adcrb_pkg::IDX_OFFCORR)
                  || (i == adcrb_pkg::IDX_GAINCORR)
                  || (i == adcrb_pkg::IDX_SEQ_ADDR)
                  || (i == adcrb_pkg::IDX_SEQ_DATA);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Helper blocks

    // R17 - ticks from the core
    assign cif.dr_tick = DR_TICK_IN;
    assign cif.raw_code = RAW_CODE_IN;
    assign cif.mod_tick = MOD_TICK_IN;
    assign cif.off_en = off_en_q;
    assign cif.gain_en = gain_en_q;
    assign cif.off_corr = offc_q;
    assign cif.gain_corr = gainc_q;
    assign cif.restart = restart_q;
    assign cif.delay_val = delay_q;
    assign cif.osr_half = adcrb_pkg::OSR_HALF_MIN << osr_q;

    adcrb_corr u_corr (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .cif(cif)
    );

    adcrb_delay u_delay (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .dif(cif)
    );

    assign CONV_START_OUT = cif.conv_start;
    assign CONV_RESET_OUT = cif.conv_reset;

    ////////////////////////////////////////////////////////////////////
    // Bus decode

    assign idx = AVS_ADDRESS_IN[6:2];
    assign seq_acc = (idx == adcrb_pkg::IDX_SEQ_DATA) && seq_act_q;
    assign eff_idx = seq_acc ? ptr_q : idx;
    // Byte addresses off a word boundary are treated as unmapped
    assign mapped = is_mapped(idx) && (AVS_ADDRESS_IN[1:0] == 2'h0);
    assign take = (AVS_READ_IN || AVS_WRITE_IN) && wait_q;
    assign wr_take = take && AVS_WRITE_IN && mapped;
    assign rd_take = take && AVS_READ_IN && mapped;
    assign wval = AVS_WRITEDATA_IN[23:0];

    always_comb begin
        wmask = 24'h000000;
        for (int b = 0; b < 3; b++) begin
            wmask[b*8 +: 8] = {8{AVS_BYTEENABLE_IN[b]}};
        end
    end

    // Newest code, including one landing this cycle
    assign live_d = cif.corr_valid ? cif.corr_code : live_q;

    // R13 - unused bits read zero
    always_comb begin
        rdata_d = 32'h00000000;
        unique case (eff_idx)
            // R02 - sequence reads frozen copy
            adcrb_pkg::IDX_RESULT: begin
                rdata_d = fmt(seq_acc ? snap_q : live_q, width_q);
            end
            adcrb_pkg::IDX_MOD: rdata_d[3:0] = mod_q;
            adcrb_pkg::IDX_DELAY: rdata_d[11:0] = delay_q;
            adcrb_pkg::IDX_GAIN: rdata_d[2:0] = gcode_q;
            adcrb_pkg::IDX_STATUS: begin
                rdata_d[23:22] = rd_loop_q;
                rdata_d[21] = wr_loop_q;
                rdata_d[17:16] = width_q;
            end
            adcrb_pkg::IDX_CONFIG: begin
                rdata_d[23] = off_en_q;
                rdata_d[22] = gain_en_q;
                rdata_d[15:13] = osr_q;
            end
            adcrb_pkg::IDX_OFFCORR: rdata_d[23:0] = offc_q;
            adcrb_pkg::IDX_GAINCORR: rdata_d[23:0] = gainc_q;
            adcrb_pkg::IDX_SEQ_ADDR: rdata_d = {26'h0, seq_act_q, ptr_q};
            default: rdata_d = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then a single low pulse

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
            resp_q <= adcrb_pkg::RESP_OK;
        end else if (take) begin
            wait_q <= 1'b0;
            rdata_q <= (AVS_READ_IN && mapped) ? rdata_d : 32'h00000000;
            resp_q <= mapped ? adcrb_pkg::RESP_OK : adcrb_pkg::RESP_SLVERR;
        end else begin
            wait_q <= 1'b1;
        end
    end

    assign AVS_WAITREQUEST_OUT = wait_q;
    assign AVS_READDATA_OUT = rdata_q;
    assign AVS_RESPONSE_OUT = resp_q;

    ////////////////////////////////////////////////////////////////////
    // Result capture

    // R01 - newest value, never written
    // R04 - whole word on each event
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            live_q <= 24'h000000;
        end else if (cif.corr_valid) begin
            live_q <= cif.corr_code;
        end
    end

    // R03 - refresh only between result reads
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            snap_q <= 24'h000000;
        end else if (wr_take && idx == adcrb_pkg::IDX_SEQ_ADDR) begin
            snap_q <= live_d;
        end else if (rd_take && seq_acc
                     && ptr_d == adcrb_pkg::IDX_RESULT) begin
            snap_q <= live_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequence pointer

    // R14 - read loop increment
    // R16 - write loop increment
    always_comb begin
        ptr_d = ptr_q;
        if (seq_acc && rd_take) begin
            ptr_d = adcrb_pkg::next_idx(ptr_q,
                        adcrb_pkg::adcrb_loop_t'(rd_loop_q));
        end else if (seq_acc && wr_take && wr_loop_q) begin
            ptr_d = adcrb_pkg::next_idx(ptr_q, adcrb_pkg::LOOP_TYPE);
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            ptr_q <= adcrb_pkg::IDX_RESULT;
            seq_act_q <= 1'b0;
        end else if (wr_take && idx == adcrb_pkg::IDX_SEQ_ADDR) begin
            ptr_q <= wval[4:0];
            seq_act_q <= wval[5];
        end else begin
            ptr_q <= ptr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Writable registers

    // R07 - tick wins over host write
    // R08 - four bits, reset 0011
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            mod_q <= adcrb_pkg::MOD_RST;
        end else if (MOD_TICK_IN) begin
            mod_q <= COMP_IN;
        end else if (wr_take && eff_idx == adcrb_pkg::IDX_MOD) begin
            mod_q <= (mod_q & ~wmask[3:0]) | (wval[3:0] & wmask[3:0]);
        end
    end

    // R10 - any delay register write restarts
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            delay_q <= 12'h000;
            restart_q <= 1'b0;
        end else begin
            restart_q <= wr_take && eff_idx == adcrb_pkg::IDX_DELAY;
            if (wr_take && eff_idx == adcrb_pkg::IDX_DELAY) begin
                delay_q <= (delay_q & ~wmask[11:0])
                         | (wval[11:0] & wmask[11:0]);
            end
        end
    end

    // R12 - gain decode
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            gcode_q <= 3'h0;
            gain_q <= adcrb_pkg::gain_of(3'h0);
        end else begin
            gain_q <= adcrb_pkg::gain_of(gcode_q);
            if (wr_take && eff_idx == adcrb_pkg::IDX_GAIN
                && AVS_BYTEENABLE_IN[0]) begin
                gcode_q <= wval[2:0];
            end
        end
    end

    assign AMP_GAIN_OUT = gain_q;

    // R15 - loop field in status
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            {rd_loop_q, wr_loop_q} <= adcrb_pkg::STATUS_RST;
            width_q <= adcrb_pkg::WIDTH_RST;
        end else if (wr_take && eff_idx == adcrb_pkg::IDX_STATUS
                     && AVS_BYTEENABLE_IN[2]) begin
            rd_loop_q <= wval[adcrb_pkg::RD_LOOP_LO +: 2];
            wr_loop_q <= wval[adcrb_pkg::WR_LOOP_BIT];
            width_q <= wval[adcrb_pkg::WIDTH_LO +: 2];
        end
    end

    // Correction enables and ratio
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            off_en_q <= 1'b0;
            gain_en_q <= 1'b0;
            osr_q <= adcrb_pkg::OSR_RST;
        end else if (wr_take && eff_idx == adcrb_pkg::IDX_CONFIG) begin
            if (AVS_BYTEENABLE_IN[2]) begin
                off_en_q <= wval[adcrb_pkg::OFF_EN_BIT];
                gain_en_q <= wval[adcrb_pkg::GAIN_EN_BIT];
            end
            if (AVS_BYTEENABLE_IN[1]) begin
                osr_q <= wval[adcrb_pkg::OSR_LO +: 3];
            end
        end
    end

    // R05 - correction coefficients
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            offc_q <= 24'h000000;
            gainc_q <= 24'h000000;
        end else if (wr_take) begin
            if (eff_idx == adcrb_pkg::IDX_OFFCORR) begin
                offc_q <= (offc_q & ~wmask) | (wval & wmask);
            end
            if (eff_idx == adcrb_pkg::IDX_GAINCORR) begin
                gainc_q <= (gainc_q & ~wmask) | (wval & wmask);
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/adcrb_core_model.sv ***
// Behavioural converter core that paces the modulator ticks
`timescale 1ns/1ps
`default_nettype none
module adcrb_core_model (
    input wire logic clk_in,
    input wire logic run_in,
    output logic mod_tick_out
);
    logic [1:0] div_q;
    ////////////////////////////////////////////////////////////////////////
    // periodic modulator tick
    // Stands still while idle, so the bench controls when counts start
    always_ff @(posedge clk_in) begin
        div_q <= run_in ? div_q + 2'h1 : 2'h0;
        mod_tick_out <= run_in && div_q == 2'h3;
    end
endmodule
`default_nettype wire

// *** sim/adcrb_sva.sv ***
// Assertion checker for the converter register bank ports
`timescale 1ns/1ps
`default_nettype none
module adcrb_sva (
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic [6:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic AVS_WAITREQUEST_OUT,
    input wire logic [1:0] AVS_RESPONSE_OUT,
    input wire logic CONV_RESET_OUT,
    input wire logic [5:0] AMP_GAIN_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);
    wire req = AVS_READ_IN | AVS_WRITE_IN;
    wire ack = !AVS_WAITREQUEST_OUT;
    ////////////////////////////////////////////////////////////////////////
    chk_wait_one: assert property (req && !ack |=> ack)
        else $error("no answer after request");
    chk_ack_single: assert property (ack |=> !ack)
        else $error("answer held too long");
    chk_refuse_resp: assert property (ack && AVS_ADDRESS_IN[1:0] != 2'h0
        |-> AVS_RESPONSE_OUT == 2'h2 && AVS_READDATA_OUT == 32'h0)
        else $error("misaligned access not refused");
    chk_mod_upper: assert property (ack && AVS_READ_IN &&
        AVS_ADDRESS_IN == 7'h20 |-> AVS_READDATA_OUT[31:4] == 28'h0)
        else $error("modulator upper bits set");
    chk_gain_upper: assert property (ack && AVS_READ_IN &&
        AVS_ADDRESS_IN == 7'h2c |-> AVS_READDATA_OUT[31:3] == 29'h0)
        else $error("gain upper bits set");
    chk_gain_legal: assert property ($onehot(AMP_GAIN_OUT) &&
        AMP_GAIN_OUT <= 6'h20)
        else $error("illegal gain multiplier");
    chk_restart_after: assert property (AVS_WRITE_IN && !ack &&
        AVS_ADDRESS_IN == 7'h28 |-> ##[1:3] CONV_RESET_OUT)
        else $error("no restart after delay write");
    chk_reset_pulse: assert property (CONV_RESET_OUT |=> !CONV_RESET_OUT)
        else $error("restart pulse too long");
    cover property (ack && AVS_READ_IN);
    cover property (CONV_RESET_OUT);
    cover property (ack && AVS_RESPONSE_OUT == 2'h2);
endmodule
bind adcrb_top adcrb_sva u_sva (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
    .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
    .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
    .AVS_RESPONSE_OUT(AVS_RESPONSE_OUT), .CONV_RESET_OUT(CONV_RESET_OUT),
    .AMP_GAIN_OUT(AMP_GAIN_OUT));
`default_nettype wire

// *** sim/test_adc_result_and_config_regs.sv ***
// Self-checking bench for the converter register bank
`timescale 1ns/1ps
`default_nettype none
module test_adc_result_and_config_regs;
    logic clk = 1'b0;
    logic srst, rd, wr, dr, run, wt, mt, st, cr;
    logic [6:0] adr;
    logic [31:0] wd, q, rdat;
    logic [3:0] be;
    logic [1:0] rsp, r;
    logic [23:0] raw;
    logic [3:0] comp;
    logic [5:0] gain;
    int miscompares = 0;
    int tests_run = 0;
    int k, n;
    logic [31:0] fmt [4] = '{32'h8765, 32'h876543, 32'h87654300,
                            32'hff876543};
    always #20 clk = ~clk;
    adcrb_top u_dut (.CLK_IN(clk), .SRST_IN(srst), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
        .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdat),
        .AVS_WAITREQUEST_OUT(wt), .AVS_RESPONSE_OUT(rsp),
        .DR_TICK_IN(dr), .RAW_CODE_IN(raw), .MOD_TICK_IN(mt),
        .COMP_IN(comp), .CONV_START_OUT(st), .CONV_RESET_OUT(cr),
        .AMP_GAIN_OUT(gain));
    adcrb_core_model u_core (.clk_in(clk), .run_in(run), .mod_tick_out(mt));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("%0d compared, %0d wrong", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [6:0] a,
                       input logic [31:0] d);
        int c;
        c = 0;
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
            c++;
        end while (wt !== 1'b0 && c < 50);
        q = rdat;
        r = rsp;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        if (c >= 50) begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic wrt(input logic [6:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic conv(input logic [23:0] c);
        dr <= 1'b1;
        raw <= c;
        @(posedge clk);
        dr <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        srst <= 1'b1;
        rd <= 1'b0;
        wr <= 1'b0;
        dr <= 1'b0;
        run <= 1'b0;
        adr <= 7'h00;
        be <= 4'hf;
        wd <= 32'h0;
        raw <= 24'h0;
        comp <= 4'h0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rdc(7'h20, 32'h3);
        rdc(7'h28, 32'h0);
        rdc(7'h30, 32'h00a10000);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            wrt(7'h2c, 32'hfffffff8 | i);
            rdc(7'h2c, i);
            chk({26'h0, gain}, (i > 5) ? 32'h1 : 32'h1 << i);
        end
        // Lane 0 off leaves the gain code alone
        be <= 4'he;
        wrt(7'h2c, 32'h2);
        be <= 4'hf;
        rdc(7'h2c, 32'h7);
        wrt(7'h28, 32'hfffff);
        rdc(7'h28, 32'hfff);
        bus(1'b0, 7'h04, 32'h0);
        chk(r, 32'h2);
        bus(1'b0, 7'h2d, 32'h0);
        chk(r, 32'h2);
        $display("fields done");
        conv(24'h876543);
        wrt(7'h00, 32'h0);
        for (int w = 0; w < 4; w++) begin
            wrt(7'h30, 32'h00a00000 | (w << 16));
            rdc(7'h00, fmt[w]);
        end
        wrt(7'h30, 32'h00a10000);
        wrt(7'h3c, 32'h10);
        wrt(7'h34, 32'h806000);
        conv(24'h000100);
        rdc(7'h00, 32'h110);
        wrt(7'h34, 32'h006000);
        conv(24'h111111);
        wrt(7'h50, 32'h20);
        conv(24'h222222);
        rdc(7'h54, 32'h111111);
        rdc(7'h00, 32'h222222);
        rdc(7'h54, 32'h222222);
        $display("result done");
        comp <= 4'ha;
        run <= 1'b1;
        repeat (20) @(posedge clk);
        // modulator register left unwritten by the host
        rdc(7'h20, 32'ha);
        for (int m = 0; m < 4; m++) begin
            wrt(7'h30, 32'h00210000 | (m << 22));
            wrt(7'h50, (m < 2) ? 32'h2b : 32'h3f);
            bus(1'b0, 7'h54, 32'h0);
            chk(q, (m < 2) ? 32'h7 : 32'h0);
            bus(1'b0, 7'h54, 32'h0);
            chk(q, (m == 3) ? 32'h222222 : (m == 0) ? 32'h7 : 32'ha);
        end
        wrt(7'h30, 32'h00a10000);
        wrt(7'h50, 32'h2a);
        wrt(7'h54, 32'h7);
        wrt(7'h54, 32'h3);
        rdc(7'h28, 32'h7);
        rdc(7'h2c, 32'h3);
        wrt(7'h30, 32'h00810000);
        wrt(7'h50, 32'h2b);
        wrt(7'h54, 32'h1);
        wrt(7'h54, 32'h4);
        rdc(7'h2c, 32'h4);
        $display("loops done");
        wrt(7'h28, 32'h5);
        k = 0;
        n = 0;
        while (st !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
            if (mt === 1'b1) k++;
        end
        chk(n < 2000, 32'h1);
        chk(k >= 133 && k <= 135, 32'h1);
        $display("start delay done");
        conclude();
    end
endmodule
`default_nettype wire
